// ===== card_detect_pkg.sv
package card_detect_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned MEAS_W = 6;

    // Register offsets
    localparam logic [7:0] OFS_Q_LOW_BORDER  = 8'h3f;
    localparam logic [7:0] OFS_Q_HIGH_BORDER = 8'h40;
    localparam logic [7:0] OFS_I_LOW_BORDER  = 8'h41;
    localparam logic [7:0] OFS_RESULT_I      = 8'h42;
    localparam logic [7:0] OFS_RESULT_Q      = 8'h43;
    localparam logic [7:0] OFS_IRQ_STATUS    = 8'h48;
    localparam logic [7:0] OFS_IRQ_MASK      = 8'h49;

    // Field positions
    localparam int unsigned BORDER_LSB   = 0;
    localparam int unsigned UPPER_PART_LSB = 6;
    localparam int unsigned SUPPRESS_BIT = 6;
    localparam int unsigned DETECT_BIT   = 0;
    localparam int unsigned RUN_DONE_BIT = 1;
    localparam int unsigned IRQ_W        = 2;

    // Reset values
    localparam logic [7:0] RST_BORDER    = 8'h00;
    localparam logic [5:0] RST_RESULT    = 6'h00;
    localparam logic [1:0] RST_IRQ       = 2'h0;

    typedef struct packed {
        logic [5:0] i_meas;
        logic [5:0] q_meas;
    } meas_t;

    typedef struct packed {
        logic [5:0] i_upper;
        logic [5:0] i_lower;
        logic [5:0] q_upper;
        logic [5:0] q_lower;
    } borders_t;

endpackage

// ===== border_compare.sv
`timescale 1ns/1ns
module border_compare (
    input  card_detect_pkg::borders_t borders,
    input  card_detect_pkg::meas_t    meas,
    output logic                      violated
);
    always_comb begin
        violated = (meas.i_meas > borders.i_upper)   // RULE2
                 | (meas.q_meas > borders.q_lower)   // RULE4
                 | (meas.q_meas > borders.q_upper)   // RULE5
                 | (meas.i_meas < borders.i_lower);  // RULE6 RULE12
    end
endmodule

// ===== card_detect_thresholds.sv
// Chosen here: strobed register access.
`timescale 1ns/1ns
// What this block does
// (RULE1) I upper border built from bits 7:6 of Q low, Q high, I low registers.
// (RULE2) I result above I upper border raises a detection request.
// (RULE3) Request sets the detection flag in the interrupt status register.
// (RULE4) Q result above the Q lower border field raises a request.
// (RULE5) Q result above the Q upper border raises a request.
// (RULE6) I result below the I lower border raises a request.
// (RULE7) Last I result readable in bits 5:0; bits 7:6 read zero.
// (RULE8) Last Q result readable in bits 5:0; bit 7 reads zero.
// (RULE9) Suppress bit blocks further requests until the next run starts.
// (RULE10) Software may set suppress after handling a detection.
// (RULE11) Results update at run end and hold until the next run ends.
// (RULE12) Borders are checked once per completed run; any violation suffices.
module card_detect_thresholds (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic [7:0]          addr,
    input  wire logic [7:0]          wdata,
    input  wire logic                wr,
    input  wire logic                rd,
    output logic      [7:0]          rdata,
    input  wire logic                run_start,
    input  wire logic                run_done,
    input  card_detect_pkg::meas_t   meas,
    output logic                     irq
);
    logic [7:0]                 q_low_ff;
    logic [7:0]                 q_high_ff;
    logic [7:0]                 i_low_ff;
    logic [5:0]                 res_i_ff;
    logic [5:0]                 res_q_ff;
    logic                       suppress_ff;
    logic [1:0]                 status_ff;
    logic [1:0]                 mask_ff;
    logic [7:0]                 rdata_ff;
    card_detect_pkg::borders_t  borders;
    logic                       violated;
    logic                       detect_evt;
    logic [1:0]                 nxt_status;
    logic [7:0]                 nxt_rdata;
    logic                       wr_status;

    always_comb begin
        borders.i_upper = {q_low_ff[7:6], q_high_ff[7:6], i_low_ff[7:6]};  // RULE1
        borders.q_lower = q_low_ff[5:0];
        borders.q_upper = q_high_ff[5:0];
        borders.i_lower = i_low_ff[5:0];
    end

    border_compare u_cmp (
        .borders  (borders),
        .meas     (meas),
        .violated (violated)
    );

    // Evaluated only at run end, gated by suppress
    assign detect_evt = run_done & violated & ~suppress_ff;  // RULE9 RULE12

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_low_ff  <= card_detect_pkg::RST_BORDER;
            q_high_ff <= card_detect_pkg::RST_BORDER;
            i_low_ff  <= card_detect_pkg::RST_BORDER;
        end else if (wr) begin
            if (addr == card_detect_pkg::OFS_Q_LOW_BORDER) begin
                q_low_ff <= wdata;
            end
            if (addr == card_detect_pkg::OFS_Q_HIGH_BORDER) begin
                q_high_ff <= wdata;
            end
            if (addr == card_detect_pkg::OFS_I_LOW_BORDER) begin
                i_low_ff <= wdata;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            res_i_ff <= card_detect_pkg::RST_RESULT;
            res_q_ff <= card_detect_pkg::RST_RESULT;
        end else if (run_done) begin
            res_i_ff <= meas.i_meas;  // RULE11
            res_q_ff <= meas.q_meas;  // RULE11
        end
    end

    // Run start clears suppress; a write in the same cycle wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            suppress_ff <= 1'b0;
        end else if (wr && addr == card_detect_pkg::OFS_RESULT_Q) begin
            suppress_ff <= wdata[card_detect_pkg::SUPPRESS_BIT];  // RULE10
        end else if (run_start) begin
            suppress_ff <= 1'b0;  // RULE9
        end
    end

    assign wr_status = wr && addr == card_detect_pkg::OFS_IRQ_STATUS;

    // Set wins over write-one-to-clear
    always_comb begin
        nxt_status = status_ff;
        if (wr_status) begin
            nxt_status = status_ff & ~wdata[1:0];
        end
        if (detect_evt) begin
            nxt_status[card_detect_pkg::DETECT_BIT] = 1'b1;  // RULE3
        end
        if (run_done) begin
            nxt_status[card_detect_pkg::RUN_DONE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_ff <= card_detect_pkg::RST_IRQ;
        end else begin
            status_ff <= nxt_status;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_ff <= card_detect_pkg::RST_IRQ;
        end else if (wr && addr == card_detect_pkg::OFS_IRQ_MASK) begin
            mask_ff <= wdata[1:0];
        end
    end

    assign irq = |(status_ff & mask_ff);

    always_comb begin
        nxt_rdata = 8'h00;
        unique case (addr)
            card_detect_pkg::OFS_Q_LOW_BORDER:  nxt_rdata = q_low_ff;
            card_detect_pkg::OFS_Q_HIGH_BORDER: nxt_rdata = q_high_ff;
            card_detect_pkg::OFS_I_LOW_BORDER:  nxt_rdata = i_low_ff;
            card_detect_pkg::OFS_RESULT_I:      nxt_rdata = {2'b00, res_i_ff};  // RULE7
            card_detect_pkg::OFS_RESULT_Q: begin
                nxt_rdata = {1'b0, suppress_ff, res_q_ff};  // RULE8
            end
            card_detect_pkg::OFS_IRQ_STATUS:    nxt_rdata = {6'h00, status_ff};
            card_detect_pkg::OFS_IRQ_MASK:      nxt_rdata = {6'h00, mask_ff};
            default:                            nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else if (rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign rdata = rdata_ff;

    a_detect_sets_flag: assert property (  // RULE3
        @(posedge clk) disable iff (rst)
        run_done && violated && !suppress_ff
        |=> status_ff[0])
        else $error("detection did not set flag");

    a_no_flag_idle: assert property (  // RULE12
        @(posedge clk) disable iff (rst)
        !run_done && !$past(status_ff[0]) && !status_ff[0]
        |=> !status_ff[0] || $past(run_done))
        else $error("flag set without run end");

    a_suppress_blocks: assert property (  // RULE9
        @(posedge clk) disable iff (rst)
        suppress_ff && !status_ff[0] && !wr_status
        |=> !status_ff[0])
        else $error("suppressed request raised");

    a_iupper_compare: assert property (  // RULE1
        @(posedge clk) disable iff (rst)
        run_done && !suppress_ff && meas.i_meas > {q_low_ff[7:6], q_high_ff[7:6], i_low_ff[7:6]}
        |=> status_ff[0])
        else $error("I upper border miss");

    a_ilow_compare: assert property (  // RULE6
        @(posedge clk) disable iff (rst)
        run_done && !suppress_ff && meas.i_meas < i_low_ff[5:0]
        |=> status_ff[0])
        else $error("I lower border miss");

    a_qhigh_compare: assert property (  // RULE5
        @(posedge clk) disable iff (rst)
        run_done && !suppress_ff && meas.q_meas > q_high_ff[5:0]
        |=> status_ff[0])
        else $error("Q upper border miss");

    a_qlow_compare: assert property (  // RULE4
        @(posedge clk) disable iff (rst)
        run_done && !suppress_ff && meas.q_meas > q_low_ff[5:0]
        |=> status_ff[0])
        else $error("Q lower border miss");

    a_result_hold: assert property (  // RULE11
        @(posedge clk) disable iff (rst)
        !run_done
        |=> $stable(res_i_ff) && $stable(res_q_ff))
        else $error("result changed outside run end");

    a_result_capture: assert property (  // RULE11
        @(posedge clk) disable iff (rst)
        run_done
        |=> res_i_ff == $past(meas.i_meas))
        else $error("I result not captured");

    a_read_reserved: assert property (  // RULE7
        @(posedge clk) disable iff (rst)
        rd && addr == card_detect_pkg::OFS_RESULT_I
        |=> rdata[7:6] == 2'h0)
        else $error("reserved I bits nonzero");

    a_read_q_bit7: assert property (  // RULE8
        @(posedge clk) disable iff (rst)
        rd && addr == card_detect_pkg::OFS_RESULT_Q
        |=> !rdata[7])
        else $error("reserved Q bit nonzero");

    a_start_clears: assert property (  // RULE9
        @(posedge clk) disable iff (rst)
        run_start && !(wr && addr == card_detect_pkg::OFS_RESULT_Q)
        |=> !suppress_ff)
        else $error("run start kept suppress");

    a_capture_q: assert property (  // RULE11
        @(posedge clk) disable iff (rst)
        run_done
        |=> res_q_ff == $past(meas.q_meas))
        else $error("Q result not captured");

    a_run_flag_set: assert property (  // RULE12
        @(posedge clk) disable iff (rst)
        run_done
        |=> status_ff[card_detect_pkg::RUN_DONE_BIT])
        else $error("run end flag not set");

    a_detect_w1c: assert property (  // RULE3
        @(posedge clk) disable iff (rst)
        wr_status && wdata[card_detect_pkg::DETECT_BIT] && !detect_evt
        |=> !status_ff[card_detect_pkg::DETECT_BIT])
        else $error("detection flag not cleared");

    a_run_flag_w1c: assert property (  // RULE3
        @(posedge clk) disable iff (rst)
        wr_status && wdata[card_detect_pkg::RUN_DONE_BIT] && !run_done
        |=> !status_ff[card_detect_pkg::RUN_DONE_BIT])
        else $error("run end flag not cleared");

    a_flag_sticky: assert property (  // RULE3
        @(posedge clk) disable iff (rst)
        status_ff[0] && !(wr_status && wdata[0])
        |=> status_ff[0])
        else $error("detection flag dropped");

    a_irq_follows: assert property (  // RULE3
        @(posedge clk) disable iff (rst)
        detect_evt && mask_ff[0] && !(wr && addr == card_detect_pkg::OFS_IRQ_MASK)
        |=> irq)
        else $error("unmasked detection without irq");

    a_read_q_low: assert property (  // RULE4
        @(posedge clk) disable iff (rst)
        rd && addr == card_detect_pkg::OFS_Q_LOW_BORDER
        |=> rdata == $past(q_low_ff))
        else $error("Q lower border readback wrong");

    a_read_q_high: assert property (  // RULE5
        @(posedge clk) disable iff (rst)
        rd && addr == card_detect_pkg::OFS_Q_HIGH_BORDER
        |=> rdata == $past(q_high_ff))
        else $error("Q upper border readback wrong");

    a_read_i_low: assert property (  // RULE6
        @(posedge clk) disable iff (rst)
        rd && addr == card_detect_pkg::OFS_I_LOW_BORDER
        |=> rdata == $past(i_low_ff))
        else $error("I lower border readback wrong");

    a_read_result_i: assert property (  // RULE7
        @(posedge clk) disable iff (rst)
        rd && addr == card_detect_pkg::OFS_RESULT_I
        |=> rdata[5:0] == $past(res_i_ff))
        else $error("I result readback wrong");

    a_read_result_q: assert property (  // RULE8
        @(posedge clk) disable iff (rst)
        rd && addr == card_detect_pkg::OFS_RESULT_Q
        |=> rdata[5:0] == $past(res_q_ff) && rdata[6] == $past(suppress_ff))
        else $error("Q result readback wrong");

    a_rdata_idle: assert property (  // RULE7
        @(posedge clk) disable iff (rst)
        !rd
        |=> rdata == 8'h00)
        else $error("read data outside read cycle");

    a_write_q_low: assert property (  // RULE1
        @(posedge clk) disable iff (rst)
        wr && addr == card_detect_pkg::OFS_Q_LOW_BORDER
        |=> q_low_ff == $past(wdata))
        else $error("Q lower border write lost");

    a_write_q_high: assert property (  // RULE5
        @(posedge clk) disable iff (rst)
        wr && addr == card_detect_pkg::OFS_Q_HIGH_BORDER
        |=> q_high_ff == $past(wdata))
        else $error("Q upper border write lost");

    a_write_i_low: assert property (  // RULE6
        @(posedge clk) disable iff (rst)
        wr && addr == card_detect_pkg::OFS_I_LOW_BORDER
        |=> i_low_ff == $past(wdata))
        else $error("I lower border write lost");

    a_suppress_write: assert property (  // RULE9
        @(posedge clk) disable iff (rst)
        wr && addr == card_detect_pkg::OFS_RESULT_Q
        |=> suppress_ff == $past(wdata[card_detect_pkg::SUPPRESS_BIT]))
        else $error("suppress write lost");

    a_suppress_hold: assert property (  // RULE9
        @(posedge clk) disable iff (rst)
        !run_start && !(wr && addr == card_detect_pkg::OFS_RESULT_Q)
        |=> $stable(suppress_ff))
        else $error("suppress changed without cause");

    a_border_hold: assert property (  // RULE1
        @(posedge clk) disable iff (rst)
        !wr
        |=> $stable(q_low_ff) && $stable(q_high_ff) && $stable(i_low_ff))
        else $error("border changed without write");

    c_detect: cover property (
        @(posedge clk) disable iff (rst)
        detect_evt ##1 irq);

    c_suppress: cover property (
        @(posedge clk) disable iff (rst)
        suppress_ff && run_done && violated);

    c_clear: cover property (
        @(posedge clk) disable iff (rst)
        status_ff[0] ##1 wr_status ##1 !status_ff[0]);

    c_clean_run: cover property (
        @(posedge clk) disable iff (rst)
        run_done && !violated);

    c_low_i: cover property (
        @(posedge clk) disable iff (rst)
        run_done && meas.i_meas < i_low_ff[5:0]);
endmodule

// ===== meas_front_end.sv
`timescale 1ns/1ns
module meas_front_end (
    input  wire logic              clk,
    input  wire logic              go,
    input  wire logic              no_start,
    input  wire logic [5:0]        i_val,
    input  wire logic [5:0]        q_val,
    input  wire logic [2:0]        delay,
    output logic                   run_start,
    output logic                   run_done,
    output card_detect_pkg::meas_t meas
);
    logic [3:0] cnt_ff = 4'h0;
    initial begin
        run_start = 1'h0;
        run_done = 1'h0;
        meas = '0;
    end
    // Result valid only in the done cycle, a toggling pattern otherwise
    always @(posedge clk) begin
        run_start <= go & ~no_start;
        run_done <= 1'h0;
        meas <= ~meas;
        cnt_ff <= go ? {1'h0, delay} + 4'h1 : cnt_ff - {3'h0, cnt_ff != 4'h0};
        if (cnt_ff == 4'h1) begin
            run_done <= 1'h1;
            meas <= {i_val, q_val};
        end
    end
endmodule

// ===== card_detect_thresholds_test.sv
`timescale 1ns/1ns
module card_detect_thresholds_test;
    logic                   clk = 1'h0;
    logic                   rst = 1'h1;
    logic [7:0]             addr = 8'h00;
    logic [7:0]             wdata = 8'h00;
    logic                   wr = 1'h0;
    logic                   rd = 1'h0;
    logic [7:0]             rdata;
    logic                   run_start;
    logic                   run_done;
    card_detect_pkg::meas_t meas;
    logic                   irq;
    logic                   go = 1'h0;
    logic                   no_start = 1'h0;
    logic [5:0]             i_val = 6'h00;
    logic [5:0]             q_val = 6'h00;
    logic [2:0]             delay = 3'h0;
    logic [5:0]             iu, il, qu, ql, mi, mq;
    logic [31:0]            seed = 32'h0000_0ccc;
    logic                   v;
    int                     n_mismatch = 0;
    int                     num_checks = 0;

    always #25 clk = ~clk;

    card_detect_thresholds i_card_detect_thresholds (.clk(clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .run_start(run_start),
        .run_done(run_done), .meas(meas), .irq(irq));
    meas_front_end i_meas_front_end (.clk(clk), .go(go), .no_start(no_start),
        .i_val(i_val), .q_val(q_val), .delay(delay), .run_start(run_start),
        .run_done(run_done), .meas(meas));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic outside(input logic [5:0] i, q);
        return (i > iu) || (i < il) || (q > qu) || (q > ql);
    endfunction

    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 check("rdata", rdata, e);
    endtask

    task automatic run(input logic [5:0] i, input logic [5:0] q, input logic ns);
        int t;
        @(posedge clk);
        i_val <= i;
        q_val <= q;
        no_start <= ns;
        delay <= rnd() & 32'h0000_0007;
        go <= 1'h1;
        @(posedge clk);
        go <= 1'h0;
        for (t = 0; t < 20 && run_done !== 1'h1; t++) @(posedge clk);
        @(posedge clk);
        #1 check("irq", {7'h00, irq}, {7'h00, outside(i, q) & ~ns});
    endtask

    task automatic complete_run();
        if (n_mismatch == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        for (int k = 0; k < 11; k++) begin
            rd_reg(8'h3f + k[7:0], 8'h00);
        end
        wr_reg(8'h49, 8'h01);
        for (int k = 0; k < 40; k++) begin
            {iu, il, qu, ql, mi, mq} = {rnd(), rnd()};
            if (k < 4) begin
                {iu, il, qu, ql} = {6'h20, 6'h10, 6'h30, 6'h3f};
                mi = k[0] ? 6'h21 : 6'h20 - {5'h00, k[1]} * 6'h11;
                mq = (k == 2) ? 6'h31 : 6'h30;
            end
            wr_reg(8'h3f, {iu[5:4], ql});
            wr_reg(8'h40, {iu[3:2], qu});
            wr_reg(8'h41, {iu[1:0], il});
            wr_reg(8'h48, 8'h03);
            wr_reg(8'h42, 8'hff);
            v = outside(mi, mq);
            run(mi, mq, 1'h0);
            rd_reg(8'h42, {2'h0, mi});
            rd_reg(8'h43, {2'h0, mq});
            rd_reg(8'h48, {6'h00, 1'h1, v});
            rd_reg(8'h42, {2'h0, mi});
            rd_reg(8'h3f, {iu[5:4], ql});
        end
        {iu, il, qu, ql} = {6'h00, 6'h00, 6'h00, 6'h00};
        wr_reg(8'h3f, 8'h00);
        wr_reg(8'h40, 8'h00);
        wr_reg(8'h41, 8'h00);
        wr_reg(8'h48, 8'h03);
        wr_reg(8'h43, 8'hff);
        rd_reg(8'h43, {2'h1, mq});
        run(6'h05, 6'h07, 1'h1);
        rd_reg(8'h48, 8'h02);
        run(6'h05, 6'h07, 1'h0);
        rd_reg(8'h43, 8'h07);
        wr_reg(8'h49, 8'h00);
        #1 check("irq", {7'h00, irq}, 8'h00);
        wr_reg(8'h49, 8'h02);
        #1 check("irq", {7'h00, irq}, 8'h01);
        wr_reg(8'h48, 8'h03);
        #1 check("irq", {7'h00, irq}, 8'h00);
        rd_reg(8'h48, 8'h00);
        complete_run();
    end
endmodule
